// ==== design/nvram_host.sv ====
// Host-side pin controller for a battery-backed byte-wide static memory
`include "nvram_host_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module nvram_host
    import nvram_host_pkg::*;
#(
    parameter int RECOVERY_CYC = `NV_POWERUP_REC_CYC,
    parameter int ADDR_W       = `NV_ADDR_W,
    parameter int DATA_W       = `NV_DATA_W
) (
    input  wire logic              CLK_SYS,
    input  wire logic              RSTN,
    input  wire nvram_host_pkg::req_t REQ,
    output var  logic              READY,
    output var  nvram_host_pkg::rsp_t RSP,
    output var  logic              PF_WARN,
    input  wire logic              PWR_FAIL_N,
    output var  logic              SELECT_LOW_ACTIVE_N,
    output var  logic              SELECT_HIGH_ACTIVE,
    output var  logic              WRITE_STROBE_N,
    output var  logic              OUTPUT_GATE_N,
    output var  logic [ADDR_W-1:0] ADDR,
    input  wire logic [DATA_W-1:0] BYTE_LINES_I,
    output var  logic [DATA_W-1:0] BYTE_LINES_O,
    output var  logic              BYTE_LINES_OE
);
    import nvram_host_pkg::*;

    localparam logic [3:0] FLOAT_LAST  = 4'(`NV_FLOAT_CYC - 1);
    localparam logic [3:0] DRIVE_LAST  = 4'(`NV_DRIVE_CYC - 1);
    localparam logic [3:0] ACCESS_LAST = 4'(`NV_ACCESS_CYC - 1);
    localparam logic [3:0] RECOV_LAST  = 4'(`NV_RECOV_CYC - 1);

    state_t      state_r;
    state_t      state_nxt;
    logic [3:0]  cnt_r;
    logic [3:0]  cnt_nxt;
    logic        take;
    logic        guard_load;
    logic        guard_done;
    logic        boot_r;

    ////////////////////////////////////////////////////////////////////////
    // Power-up guard timer

    // Loaded at reset, in every ST_FAIL cycle and while the interrupt is low in ST_GUARD, so the
    // device is never selected after a release seen in one of those before its full recovery delay
    // The timer's own reset clears it, so the first cycle out of reset
    // loads it here; otherwise the guard would end at once
    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
            boot_r <= 1'b1;
        else
            boot_r <= 1'b0;
    end

    assign guard_load = boot_r || (state_r == ST_FAIL) ||
                        (state_r == ST_GUARD && !PWR_FAIL_N);

    interval_timer #(
        .W (17)
    ) u_guard (
        .clk      (CLK_SYS),
        .rst_n    (RSTN),
        .load     (guard_load || !RSTN),
        .load_val (17'(RECOVERY_CYC)),
        .done     (guard_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    // New work is refused while the interrupt is low: the device may cut off
    // on its own within 10 us
    assign take = REQ.valid && READY && PWR_FAIL_N;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r + 4'h1;
        case (state_r)
            ST_GUARD:
            begin
                cnt_nxt = 4'h0;
                // Kept deselected while the supply rises
                if (guard_done && PWR_FAIL_N)
                    state_nxt = ST_IDLE;
            end
            ST_IDLE:
            begin
                cnt_nxt = 4'h0;
                if (!PWR_FAIL_N)
                    state_nxt = ST_FAIL;
                else if (take)
                    state_nxt = REQ.write ? ST_WR_FLOAT : ST_RD;
            end
            ST_WR_FLOAT:
            begin
                // Strobe low, data held off until the device has floated
                if (cnt_r == FLOAT_LAST)
                begin
                    state_nxt = ST_WR_DRIVE;
                    cnt_nxt   = 4'h0;
                end
            end
            ST_WR_DRIVE:
            begin
                if (cnt_r == DRIVE_LAST)
                begin
                    state_nxt = ST_WR_HOLD;
                    cnt_nxt   = 4'h0;
                end
            end
            ST_WR_HOLD:
            begin
                state_nxt = ST_RECOVER;
                cnt_nxt   = 4'h0;
            end
            ST_RD:
            begin
                if (cnt_r == ACCESS_LAST)
                begin
                    state_nxt = ST_RECOVER;
                    cnt_nxt   = 4'h0;
                end
            end
            ST_RECOVER:
            begin
                // Deselected gap before the next cycle
                if (cnt_r == RECOV_LAST)
                begin
                    state_nxt = PWR_FAIL_N ? ST_IDLE : ST_FAIL;
                    cnt_nxt   = 4'h0;
                end
            end
            ST_FAIL:
            begin
                cnt_nxt = 4'h0;
                if (PWR_FAIL_N)
                    state_nxt = ST_GUARD;
            end
            default:
            begin
                state_nxt = ST_GUARD;
                cnt_nxt   = 4'h0;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
        begin
            state_r <= ST_GUARD;
            cnt_r   <= 4'h0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory control pins decoded from the next state so they leave flops; address and write data load on take

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
        begin
            SELECT_LOW_ACTIVE_N <= 1'b1;
            SELECT_HIGH_ACTIVE  <= 1'b0;
        end
        else
        begin
            // Both selects move together, so the strobe alone frames a write
            SELECT_LOW_ACTIVE_N <= !(state_nxt inside
                {ST_WR_FLOAT, ST_WR_DRIVE, ST_WR_HOLD, ST_RD});
            SELECT_HIGH_ACTIVE  <= (state_nxt inside
                {ST_WR_FLOAT, ST_WR_DRIVE, ST_WR_HOLD, ST_RD});
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
            WRITE_STROBE_N <= 1'b1;
        else
            WRITE_STROBE_N <= !(state_nxt inside
                {ST_WR_FLOAT, ST_WR_DRIVE});
    end

    // Gate only opens for reads; held high during writes regardless
    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
            OUTPUT_GATE_N <= 1'b1;
        else
            OUTPUT_GATE_N <= (state_nxt != ST_RD);
    end

    // Address captured once and untouched until the cycle is idle again
    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
            ADDR <= '0;
        else if (take)
            ADDR <= REQ.addr;
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
            BYTE_LINES_O <= '0;
        else if (take && REQ.write)
            BYTE_LINES_O <= REQ.wdata;
    end

    // Data kept one cycle past the strobe rise for hold time
    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
            BYTE_LINES_OE <= 1'b0;
        else
            BYTE_LINES_OE <= (state_nxt inside
                {ST_WR_DRIVE, ST_WR_HOLD});
    end

    ////////////////////////////////////////////////////////////////////////
    // User side

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
            READY <= 1'b0;
        else
            READY <= (state_nxt == ST_IDLE);
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
            PF_WARN <= 1'b0;
        else
            PF_WARN <= !PWR_FAIL_N;
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RSTN)
            RSP <= '0;
        else
        begin
            RSP.done <= (state_r == ST_WR_HOLD) ||
                        (state_r == ST_RD && cnt_r == ACCESS_LAST);
            if (state_r == ST_RD && cnt_r == ACCESS_LAST)
                RSP.rdata <= BYTE_LINES_I;
        end
    end
endmodule // nvram_host
`default_nettype wire

// ==== common/nvram_host_defs.svh ====
// Timing constants and pin widths for the battery-backed memory host
`ifndef NVRAM_HOST_DEFS_SVH
`define NVRAM_HOST_DEFS_SVH

// System clock rate
`define NV_CLK_MHZ          40

// Pin widths
`define NV_ADDR_W           13
`define NV_DATA_W           8

// Times as printed, in ns or us
`define NV_STROBE_FLOAT_NS  50
`define NV_PULSE_NS         80
`define NV_DATA_VALID_NS    50
`define NV_ACCESS_NS        100
`define NV_SEL_RECOVERY_NS  10
`define NV_POWERUP_REC_US   1000

// Least times rounded up to whole cycles, never below one
`define NV_CEIL_CYC(ns) \
    ((((ns) * `NV_CLK_MHZ + 999) / 1000) < 1 ? 1 : \
     (((ns) * `NV_CLK_MHZ + 999) / 1000))

`define NV_FLOAT_CYC        `NV_CEIL_CYC(`NV_STROBE_FLOAT_NS)
`define NV_PULSE_CYC        `NV_CEIL_CYC(`NV_PULSE_NS)
`define NV_DV_CYC           `NV_CEIL_CYC(`NV_DATA_VALID_NS)
`define NV_ACCESS_CYC       `NV_CEIL_CYC(`NV_ACCESS_NS)
`define NV_RECOV_CYC        `NV_CEIL_CYC(`NV_SEL_RECOVERY_NS)
`define NV_DRIVE_CYC \
    ((`NV_PULSE_CYC - `NV_FLOAT_CYC) > `NV_DV_CYC ? \
     (`NV_PULSE_CYC - `NV_FLOAT_CYC) : `NV_DV_CYC)
`define NV_POWERUP_REC_CYC  (`NV_POWERUP_REC_US * `NV_CLK_MHZ)

`endif

// ==== common/nvram_host_pkg.sv ====
// Types shared by the battery-backed memory host
package nvram_host_pkg;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [12:0] addr;
        logic [7:0] wdata;
    } req_t;

    typedef struct packed {
        logic       done;
        logic [7:0] rdata;
    } rsp_t;

    typedef enum logic [3:0] {
        ST_GUARD    = 4'h0,
        ST_IDLE     = 4'h1,
        ST_WR_FLOAT = 4'h2,
        ST_WR_DRIVE = 4'h3,
        ST_WR_HOLD  = 4'h4,
        ST_RD       = 4'h5,
        ST_RECOVER  = 4'h6,
        ST_FAIL     = 4'h7
    } state_t;

endpackage

// ==== design/interval_timer.sv ====
// Down-counting interval timer with a done level
`timescale 1ns/1ps
`default_nettype none
module interval_timer #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output var  logic         done
);
    logic [W-1:0] cnt_r;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cnt_r <= '0;
        else if (load)
            cnt_r <= load_val;
        else if (cnt_r != '0)
            cnt_r <= cnt_r - 1'b1;
    end

    assign done = (cnt_r == '0) && !load;
endmodule // interval_timer
`default_nettype wire

// ==== tb/nvram_device_model.sv ====
// Behavioural battery-backed byte memory with power-fail guard
`timescale 1ns/1ps
`default_nettype none
module nvram_device_model #(
    parameter int DESEL_NS = 10000,
    parameter int REC_NS   = 800
) (
    input  wire logic        sel_n,
    input  wire logic        sel,
    input  wire logic        strobe_n,
    input  wire logic        gate_n,
    input  wire logic [12:0] addr,
    input  wire logic        host_oe,
    input  wire logic [7:0]  host_o,
    input  wire logic        supply_bad,
    input  wire logic        slow,
    output var  logic [7:0]  lines,
    output var  logic        int_n,
    output var  logic        viol
);
    logic [7:0]  mem [0:8191];
    logic [7:0]  rd_q;
    logic [7:0]  last;
    logic [12:0] a0;
    logic        off;
    logic        on;
    logic        wr;
    logic        drv;
    logic        armed;

    initial
    begin
        armed = 1'b0;
        off = 1'b0;
        viol = 1'b0;
        last = 8'h00;
    end
    // Array is never cleared on supply loss: the cell keeps it
    assign int_n = !supply_bad;
    assign on    = !sel_n && sel && !off;
    assign wr    = on && !strobe_n;
    assign drv   = on && !gate_n && strobe_n;
    // Undriven lines show the inverse of the last value, never a kind copy
    assign lines = host_oe ? host_o : (drv ? rd_q : ~last);
    always @(lines)
        if (host_oe || drv)
            last = lines;
    always @(posedge supply_bad)
        #(DESEL_NS) off = 1'b1;
    // Shortened recovery so the run stays brief
    always @(negedge supply_bad)
        #(REC_NS) off = 1'b0;
    // Only a real write ends a write: the unknown-to-low step at reset
    // must neither store nor flag an address change
    always @(posedge wr)
    begin
        #1;
        a0 = addr;
        armed = 1'b1;
    end
    always @(negedge wr)
        if (armed)
        begin
            armed = 1'b0;
            mem[addr] = lines;
            if (addr !== a0)
                viol = 1'b1;
        end
    always @(host_oe or drv)
        if (host_oe && drv)
            viol = 1'b1;
    always @(negedge strobe_n)
        if (off && !sel_n && sel)
            viol = 1'b1;
    always @(addr or drv)
    begin
        rd_q = ~last;
        #(slow ? 90 : 10);
        rd_q = mem[addr];
    end
endmodule // nvram_device_model
`default_nettype wire

// ==== tb/nvram_host_checker.sv ====
// Pin-level checks on the memory host
`timescale 1ns/1ps
`default_nettype none
module nvram_host_checker
    import nvram_host_pkg::*;
#(
    parameter int ADDR_W = 13,
    parameter int DATA_W = 8
) (
    input wire logic              CLK_SYS,
    input wire logic              RSTN,
    input wire nvram_host_pkg::rsp_t RSP,
    input wire logic              PF_WARN,
    input wire logic              PWR_FAIL_N,
    input wire logic              SELECT_LOW_ACTIVE_N,
    input wire logic              SELECT_HIGH_ACTIVE,
    input wire logic              WRITE_STROBE_N,
    input wire logic              OUTPUT_GATE_N,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] BYTE_LINES_O,
    input wire logic              BYTE_LINES_OE
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RSTN);
    ////////////////////////////////////////////////////////////////////////
    chk_sel_pair: assert property (
        SELECT_HIGH_ACTIVE == !SELECT_LOW_ACTIVE_N) else $error("sel pair");
    chk_addr_hold: assert property (
        !SELECT_LOW_ACTIVE_N && !$past(SELECT_LOW_ACTIVE_N) |-> $stable(ADDR))
        else $error("addr moved");
    chk_gap_cycle: assert property (
        $rose(SELECT_LOW_ACTIVE_N) |=> SELECT_LOW_ACTIVE_N) else $error("gap");
    chk_no_clash: assert property (
        BYTE_LINES_OE |-> OUTPUT_GATE_N && !SELECT_LOW_ACTIVE_N)
        else $error("data clash");
    // Host waits the float delay before driving data
    chk_pulse_shape: assert property (
        $fell(WRITE_STROBE_N) |-> (!WRITE_STROBE_N && !BYTE_LINES_OE)[*2]
        ##1 (!WRITE_STROBE_N && BYTE_LINES_OE)[*2] ##1 WRITE_STROBE_N)
        else $error("strobe shape");
    chk_write_end: assert property (
        $rose(WRITE_STROBE_N) |-> BYTE_LINES_OE && $stable(BYTE_LINES_O)
        ##1 RSP.done && SELECT_LOW_ACTIVE_N) else $error("write end");
    chk_read_frame: assert property (
        $fell(OUTPUT_GATE_N) |-> (!OUTPUT_GATE_N && !SELECT_LOW_ACTIVE_N)[*4]
        ##1 (OUTPUT_GATE_N && RSP.done)) else $error("read frame");
    chk_warn_rise: assert property (
        $fell(PWR_FAIL_N) |=> PF_WARN) else $error("no warning");
    chk_fail_hold: assert property (
        !PWR_FAIL_N && SELECT_LOW_ACTIVE_N |=> SELECT_LOW_ACTIVE_N)
        else $error("select in fail");
    cover property ($rose(WRITE_STROBE_N));
    cover property ($rose(OUTPUT_GATE_N));
    cover property ($fell(PWR_FAIL_N));
endmodule // nvram_host_checker
`default_nettype wire

// ==== tb/test_nvram_write_and_power_fail_guard.sv ====
// Self-checking bench for the memory host against a device model
`timescale 1ns/1ps
`default_nettype none
module test_nvram_write_and_power_fail_guard;
    import nvram_host_pkg::*;
    logic        clk, rstn, ready, pf_warn, pwr_fail_n, sel_n, sel;
    logic        strobe_n, gate_n, oe, supply_bad, slow, viol;
    req_t        req;
    rsp_t        rsp;
    logic [12:0] addr;
    logic [7:0]  lines, bl_o, q;
    int          fails, checks_done, cycles;

    nvram_host #(.RECOVERY_CYC(40)) uut (
        .CLK_SYS(clk), .RSTN(rstn), .REQ(req), .READY(ready), .RSP(rsp),
        .PF_WARN(pf_warn), .PWR_FAIL_N(pwr_fail_n),
        .SELECT_LOW_ACTIVE_N(sel_n), .SELECT_HIGH_ACTIVE(sel),
        .WRITE_STROBE_N(strobe_n), .OUTPUT_GATE_N(gate_n), .ADDR(addr),
        .BYTE_LINES_I(lines), .BYTE_LINES_O(bl_o), .BYTE_LINES_OE(oe));
    nvram_device_model dev (
        .sel_n(sel_n), .sel(sel), .strobe_n(strobe_n), .gate_n(gate_n),
        .addr(addr), .host_oe(oe), .host_o(bl_o), .supply_bad(supply_bad),
        .slow(slow), .lines(lines), .int_n(pwr_fail_n), .viol(viol));
    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    task automatic cmp_bit(input logic e, input logic g);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value at %0t: exp %h got %h", $time, e, g);
        end
    endtask
    // Holds the request until taken, then waits for the done pulse
    task automatic access(input logic w, input logic [12:0] a,
                          input logic [7:0] d, output logic [7:0] r);
        int n;
        @(negedge clk);
        req = '{1'b1, w, a, d};
        for (n = 0; n < 3000 && !(ready === 1'b1 && pwr_fail_n === 1'b1); n++)
            @(negedge clk);
        @(negedge clk);
        req.valid = 1'b0;
        for (n = 0; n < 20 && rsp.done !== 1'b1; n++)
            @(negedge clk);
        cmp_bit(1'b1, rsp.done);
        r = rsp.rdata;
    endtask
    task automatic t_rw;
        logic [12:0] a [4] = '{13'h0000, 13'h1FFF, 13'h0AAA, 13'h1555};
        logic [7:0]  d [4] = '{8'hA5, 8'h5A, 8'h00, 8'hFF};
        for (int i = 0; i < 4; i++)
            access(1'b1, a[i], d[i], q);
        for (int i = 0; i < 4; i++)
        begin
            access(1'b0, a[i], 8'h00, q);
            cmp_byte(d[i], q);
        end
    endtask
    task automatic t_slow;
        slow = 1'b1;
        access(1'b0, 13'h1FFF, 8'h00, q);
        cmp_byte(8'h5A, q);
        slow = 1'b0;
    endtask
    task automatic t_fail;
        fork
            access(1'b1, 13'h0100, 8'hC3, q);
            begin
                repeat (3) @(negedge clk);
                supply_bad = 1'b1;
            end
        join
        cmp_bit(1'b1, pf_warn);
        fork
            access(1'b1, 13'h0AAA, 8'h3C, q);
            begin
                repeat (500) @(negedge clk);
                cmp_bit(1'b1, sel_n);
                supply_bad = 1'b0;
            end
        join
        cmp_bit(1'b0, pf_warn);
        access(1'b0, 13'h0100, 8'h00, q);
        cmp_byte(8'hC3, q);
        access(1'b0, 13'h1555, 8'h00, q);
        cmp_byte(8'hFF, q);
        access(1'b0, 13'h0AAA, 8'h00, q);
        cmp_byte(8'h3C, q);
        cmp_bit(1'b0, viol);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // A hang is cut short well beyond the longest expected run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            fails++;
            wrap_up();
        end
    end
    initial
    begin
        req = '0;
        rstn = 1'b0;
        supply_bad = 1'b0;
        slow = 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        cmp_bit(1'b1, sel_n);
        cmp_bit(1'b1, strobe_n);
        cmp_bit(1'b0, oe);
        rstn = 1'b1;
        // Guard must keep the host idle well into the recovery delay
        repeat (20) @(negedge clk);
        cmp_bit(1'b0, ready);
        cmp_bit(1'b1, sel_n);
        t_rw();
        t_slow();
        t_fail();
        wrap_up();
    end
endmodule // test_nvram_write_and_power_fail_guard
bind nvram_host nvram_host_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .RSP(RSP), .PF_WARN(PF_WARN),
    .PWR_FAIL_N(PWR_FAIL_N), .SELECT_LOW_ACTIVE_N(SELECT_LOW_ACTIVE_N),
    .SELECT_HIGH_ACTIVE(SELECT_HIGH_ACTIVE), .ADDR(ADDR),
    .WRITE_STROBE_N(WRITE_STROBE_N), .OUTPUT_GATE_N(OUTPUT_GATE_N),
    .BYTE_LINES_O(BYTE_LINES_O), .BYTE_LINES_OE(BYTE_LINES_OE));
`default_nettype wire
